// >>> rtl/sfc_params.svh
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_DELIM 8'h7e
`define SFC_ESC 8'h7d
`define SFC_XON 8'h11
`define SFC_XOFF 8'h13
`define SFC_ESC_XOR 8'h20
`define SFC_CSUM_OK 8'hff
`define SFC_MODE_TRANSP 2'h0
`define SFC_MODE_API 2'h1
`define SFC_MODE_API_ESC 2'h2
`define SFC_FIFO_DEPTH 16
`endif

// >>> rtl/sfc_pkg.sv
package sfc_pkg;
  typedef logic [7:0] sfc_byte_t;
  typedef logic [1:0] sfc_mode_t;
  function automatic logic sfc_reserved(input logic [7:0] b);
    sfc_reserved = (b == 8'h7e) || (b == 8'h7d) ||
                   (b == 8'h11) || (b == 8'h13);
  endfunction
endpackage

// >>> rtl/sfc_link_if.sv
`timescale 1ns/100ps
interface sfc_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport dev (input h2d_data, input h2d_valid, output h2d_ready,
    output d2h_data, output d2h_valid, input d2h_ready);
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
    input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// >>> rtl/sfc_fifo.sv
`timescale 1ns/100ps
module sfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clr,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (clr) begin
        wr_ff <= '0;
        rd_ff <= '0;
        cnt_ff <= '0;
      end else begin
        if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
        if (pop) rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
        cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) mem_ff[wr_ff] <= in_data;
  end
endmodule // sfc_fifo

// >>> rtl/sfc_dev.sv
`timescale 1ns/100ps
`include "sfc_params.svh"
module sfc_dev
  import sfc_pkg::*;
#(
  parameter int DEPTH = `SFC_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] framing_mode_select,
  input wire logic link_is_spi,
  sfc_link_if.dev link,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_first,
  output logic rx_last,
  input wire logic rx_ready,
  output logic rx_drop,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready
);
  // ****************************************************************
  // receive deframer
  // ****************************************************************
  typedef enum logic [5:0] {
    RX_HUNT = 6'h01, RX_LENH = 6'h02, RX_LENL = 6'h04,
    RX_DATA = 6'h08, RX_CSUM = 6'h10, RX_PASS = 6'h20
  } sfc_rx_st_t;
  sfc_rx_st_t rst_ff, nxt_rst;
  logic esc_ff, nxt_esc;
  logic [15:0] len_ff, nxt_len, cnt_ff, nxt_cnt;
  logic [7:0] sum_ff, nxt_sum;
  logic drop_ff, nxt_drop;
  logic [8:0] fin_data, fout_data;
  logic fin_valid, fin_ready, fclr, fout_valid;
  logic [15:0] fill_ff, nxt_fill;
  logic stuffed, is_delim, eff_valid;
  logic [7:0] b;
  sfc_mode_t mode;
  logic pop, fout_ready, take_ok;
  logic [7:0] rxd_ff;
  logic rxv_ff, rxf_ff, rxl_ff;
  assign mode = (link_is_spi && framing_mode_select == `SFC_MODE_API_ESC)
    ? `SFC_MODE_API : framing_mode_select;
  assign stuffed = (mode == `SFC_MODE_API_ESC);
  // in API modes, bytes outside RX_DATA never wait on the fifo
  assign take_ok = fin_ready ||
    (mode != `SFC_MODE_TRANSP && rst_ff != RX_DATA);
  assign link.h2d_ready = take_ok;
  always_comb begin
    nxt_rst = rst_ff;
    nxt_esc = esc_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_sum = sum_ff;
    nxt_drop = 1'b0;
    fin_valid = 1'b0;
    fin_data = {1'b0, link.h2d_data};
    fclr = 1'b0;
    is_delim = link.h2d_data == `SFC_DELIM;
    eff_valid = 1'b0;
    b = link.h2d_data;
    if (link.h2d_valid && take_ok) begin
      if (mode == `SFC_MODE_TRANSP) begin
        nxt_rst = RX_PASS;
        fin_valid = 1'b1;
        fin_data = {1'b1, link.h2d_data};
      end else if (stuffed && is_delim && rst_ff != RX_HUNT) begin
        fclr = (rst_ff == RX_DATA || rst_ff == RX_CSUM);
        nxt_esc = 1'b0;
        nxt_rst = RX_LENH;
      end else if (stuffed && !esc_ff && b == `SFC_ESC &&
                   rst_ff != RX_HUNT) begin
        nxt_esc = 1'b1;
      end else begin
        if (esc_ff) b = b ^ `SFC_ESC_XOR;
        nxt_esc = 1'b0;
        eff_valid = 1'b1;
      end
    end
    if (eff_valid) begin
      case (rst_ff)
        RX_HUNT, RX_PASS: begin
          if (is_delim) nxt_rst = RX_LENH;
          else nxt_rst = RX_HUNT;
        end
        RX_LENH: begin
          nxt_len = {b, 8'h00};
          nxt_rst = RX_LENL;
        end
        RX_LENL: begin
          nxt_len = {len_ff[15:8], b};
          nxt_cnt = '0;
          nxt_sum = '0;
          if ({len_ff[15:8], b} == 16'h0000) begin
            nxt_rst = RX_HUNT; // frame without type is malformed
            nxt_drop = 1'b1;
          end else nxt_rst = RX_DATA;
        end
        RX_DATA: begin
          nxt_sum = sum_ff + b;
          nxt_cnt = cnt_ff + 16'h0001;
          fin_valid = 1'b1;
          fin_data = {cnt_ff == 16'h0000, b}; // first byte marked
          if (cnt_ff + 16'h0001 == len_ff) nxt_rst = RX_CSUM;
        end
        RX_CSUM: begin
          nxt_rst = RX_HUNT;
          if (8'(sum_ff + b) != `SFC_CSUM_OK) begin
            fclr = 1'b1;
            nxt_drop = 1'b1;
          end
        end
        default: nxt_rst = RX_HUNT;
      endcase
    end
  end
  // in API modes, release only whole verified frames
  always_comb begin
    nxt_fill = fill_ff;
    if (pop && fill_ff != '0) nxt_fill = fill_ff - 16'h0001;
    if (rst_ff == RX_CSUM && eff_valid && !nxt_drop)
      nxt_fill = nxt_fill + cnt_ff;
    if (fclr || mode == `SFC_MODE_TRANSP) nxt_fill = '0;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_ff <= RX_HUNT;
      esc_ff <= 1'b0;
      len_ff <= '0;
      cnt_ff <= '0;
      sum_ff <= '0;
      drop_ff <= 1'b0;
      fill_ff <= '0;
    end else if (clk_en) begin
      rst_ff <= nxt_rst;
      esc_ff <= nxt_esc;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      sum_ff <= nxt_sum;
      drop_ff <= nxt_drop;
      fill_ff <= nxt_fill;
    end
  end
  assign pop = fout_valid && (mode == `SFC_MODE_TRANSP || fill_ff != '0) &&
    (!rxv_ff || rx_ready);
  assign fout_ready = pop;
  sfc_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_rxq (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .clr(fclr),
    .in_data(fin_data), .in_valid(fin_valid), .in_ready(fin_ready),
    .out_data(fout_data), .out_valid(fout_valid), .out_ready(fout_ready));
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_ff <= '0;
      rxv_ff <= 1'b0;
      rxf_ff <= 1'b0;
      rxl_ff <= 1'b0;
    end else if (clk_en) begin
      if (pop) begin
        rxd_ff <= fout_data[7:0];
        rxv_ff <= 1'b1;
        rxf_ff <= fout_data[8];
        rxl_ff <= (fill_ff == 16'h0001) && mode != `SFC_MODE_TRANSP;
      end else if (rx_ready) rxv_ff <= 1'b0;
    end
  end
  assign rx_data = rxd_ff;
  assign rx_valid = rxv_ff;
  assign rx_first = rxf_ff;
  assign rx_last = rxl_ff;
  assign rx_drop = drop_ff;
  // ****************************************************************
  // transmit framer
  // ****************************************************************
  sfc_host_tx u_tx (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .stuffed(stuffed), .transp(mode == `SFC_MODE_TRANSP),
    .in_data(tx_data), .in_valid(tx_valid), .in_last(tx_last),
    .in_ready(tx_ready), .out_data(link.d2h_data),
    .out_valid(link.d2h_valid), .out_ready(link.d2h_ready));
endmodule // sfc_dev

// >>> rtl/sfc_host.sv
`timescale 1ns/100ps
`include "sfc_params.svh"
module sfc_host_tx
  import sfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic stuffed,
  input wire logic transp,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  input wire logic in_last,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(`SFC_FIFO_DEPTH);
  typedef enum logic [5:0] {
    TX_COL = 6'h01, TX_DEL = 6'h02, TX_LH = 6'h04,
    TX_LL = 6'h08, TX_DAT = 6'h10, TX_CS = 6'h20
  } sfc_tx_st_t;
  logic [7:0] buf_ff [`SFC_FIFO_DEPTH];
  sfc_tx_st_t st_ff, nxt_st;
  logic [AW:0] n_ff, nxt_n, i_ff, nxt_i;
  logic [7:0] sum_ff, nxt_sum, od_ff, nxt_od, cur;
  logic ov_ff, nxt_ov, esc_ff, nxt_esc, wr;
  logic [7:0] tpd_ff, nxt_tpd;
  logic tpv_ff, nxt_tpv;
  assign in_ready = transp ? (!tpv_ff || out_ready) : (st_ff == TX_COL &&
    n_ff != (AW+1)'(`SFC_FIFO_DEPTH));
  assign wr = in_valid && in_ready && !transp;
  always_comb begin
    nxt_st = st_ff;
    nxt_n = n_ff;
    nxt_i = i_ff;
    nxt_sum = sum_ff;
    nxt_od = od_ff;
    nxt_ov = ov_ff;
    nxt_esc = esc_ff;
    nxt_tpd = tpd_ff;
    nxt_tpv = tpv_ff && !out_ready;
    cur = 8'h00;
    if (transp && in_valid && in_ready) begin
      nxt_tpd = in_data;
      nxt_tpv = 1'b1;
    end
    if (ov_ff && out_ready) nxt_ov = 1'b0;
    case (st_ff)
      TX_COL: if (wr) begin
        nxt_n = n_ff + 1'b1;
        nxt_sum = sum_ff + in_data;
        if (in_last) nxt_st = TX_DEL;
      end
      TX_DEL, TX_LH, TX_LL, TX_DAT, TX_CS: begin
        case (st_ff)
          TX_LH: cur = 8'h00;
          TX_LL: cur = 8'(n_ff);
          TX_DAT: cur = buf_ff[i_ff[AW-1:0]];
          TX_CS: cur = `SFC_CSUM_OK - sum_ff;
          default: cur = `SFC_DELIM;
        endcase
        if (!ov_ff || out_ready) begin
          nxt_ov = 1'b1;
          if (st_ff != TX_DEL && stuffed && !esc_ff && sfc_reserved(cur))
          begin
            nxt_od = `SFC_ESC;
            nxt_esc = 1'b1;
          end else begin
            nxt_od = esc_ff ? cur ^ `SFC_ESC_XOR : cur;
            nxt_esc = 1'b0;
            case (st_ff)
              TX_DEL: nxt_st = TX_LH;
              TX_LH: nxt_st = TX_LL;
              TX_LL: begin
                nxt_st = TX_DAT;
                nxt_i = '0;
              end
              TX_DAT: begin
                nxt_i = i_ff + 1'b1;
                if (i_ff + 1'b1 == n_ff) nxt_st = TX_CS;
              end
              default: begin
                nxt_st = TX_COL;
                nxt_n = '0;
                nxt_sum = '0;
              end
            endcase
          end
        end
      end
      default: nxt_st = TX_COL;
    endcase
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= TX_COL;
      n_ff <= '0;
      i_ff <= '0;
      sum_ff <= '0;
      od_ff <= '0;
      ov_ff <= 1'b0;
      esc_ff <= 1'b0;
      tpd_ff <= '0;
      tpv_ff <= 1'b0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      n_ff <= nxt_n;
      i_ff <= nxt_i;
      sum_ff <= nxt_sum;
      od_ff <= nxt_od;
      ov_ff <= nxt_ov;
      esc_ff <= nxt_esc;
      tpd_ff <= nxt_tpd;
      tpv_ff <= nxt_tpv;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr) buf_ff[n_ff[AW-1:0]] <= in_data;
  end
  assign out_data = transp ? tpd_ff : od_ff;
  assign out_valid = transp ? tpv_ff : ov_ff;
endmodule // sfc_host_tx

module sfc_host
  import sfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [1:0] framing_mode_select,
  sfc_link_if.host link,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic [7:0] resp_data,
  output logic resp_valid,
  input wire logic resp_ready
);
  // ****************************************************************
  // host end: frames commands, accepts raw responses
  // ****************************************************************
  logic [7:0] rd_ff;
  logic rv_ff;
  sfc_host_tx u_tx (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .stuffed(framing_mode_select == `SFC_MODE_API_ESC),
    .transp(framing_mode_select == `SFC_MODE_TRANSP),
    .in_data(cmd_data), .in_valid(cmd_valid), .in_last(cmd_last),
    .in_ready(cmd_ready), .out_data(link.h2d_data),
    .out_valid(link.h2d_valid), .out_ready(link.h2d_ready));
  assign link.d2h_ready = !rv_ff || resp_ready;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ff <= '0;
      rv_ff <= 1'b0;
    end else if (clk_en) begin
      if (link.d2h_valid && link.d2h_ready) begin
        rd_ff <= link.d2h_data; // types passed unfiltered
        rv_ff <= 1'b1;
      end else if (resp_ready) rv_ff <= 1'b0;
    end
  end
  assign resp_data = rd_ff;
  assign resp_valid = rv_ff;
endmodule // sfc_host

// >>> verif/sfc_link_chk_sva.sv
`timescale 1ns/100ps
module sfc_link_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] framing_mode_select,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  // ********************************
  // frame tracker on device-to-host
  // ********************************
  logic [2:0] st_ff;
  logic [15:0] cnt_ff;
  logic [7:0] sum_ff, lenh_ff, eff, ck;
  logic esc_ff, tk, stf, mk;
  assign tk = d2h_valid && d2h_ready && framing_mode_select != 2'h0;
  assign stf = framing_mode_select == 2'h2;
  assign mk = stf && !esc_ff && d2h_data == 8'h7d && st_ff != 3'h0;
  assign eff = esc_ff ? d2h_data ^ 8'h20 : d2h_data;
  assign ck = sum_ff + eff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= 3'h0;
      cnt_ff <= 16'h0;
      sum_ff <= 8'h0;
      lenh_ff <= 8'h0;
      esc_ff <= 1'b0;
    end else if (tk) begin
      esc_ff <= mk;
      if (!mk) begin
        case (st_ff)
          3'h0: st_ff <= 3'h1;
          3'h1: begin
            lenh_ff <= eff;
            st_ff <= 3'h2;
          end
          3'h2: begin
            cnt_ff <= {lenh_ff, eff};
            sum_ff <= 8'h0;
            st_ff <= 3'h3;
          end
          3'h3: begin
            sum_ff <= ck;
            cnt_ff <= cnt_ff - 16'h1;
            if (cnt_ff == 16'h1) st_ff <= 3'h4;
          end
          default: st_ff <= 3'h0;
        endcase
      end
    end
  end
  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_d2h_hold;
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
  endproperty
  a_d2h_hold: assert property (p_d2h_hold)
    else $error("device byte changed before taken");
  property p_h2d_hold;
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
  endproperty
  a_h2d_hold: assert property (p_h2d_hold)
    else $error("host byte changed before taken");
  property p_idle;
    $fell(sys_rst) |-> !d2h_valid && !h2d_valid;
  endproperty
  a_idle: assert property (p_idle)
    else $error("valid high right after reset");
  property p_delim;
    tk && st_ff == 3'h0 |-> d2h_data == 8'h7e;
  endproperty
  a_delim: assert property (p_delim)
    else $error("frame does not open with delimiter");
  property p_len;
    tk && !mk && st_ff == 3'h2 |-> {lenh_ff, eff} != 16'h0;
  endproperty
  a_len: assert property (p_len)
    else $error("zero length frame sent");
  property p_csum;
    tk && !mk && st_ff == 3'h4 |-> ck == 8'hff;
  endproperty
  a_csum: assert property (p_csum)
    else $error("checksum does not verify");
  property p_raw;
    tk && stf && !esc_ff && st_ff != 3'h0
      |-> !(d2h_data inside {8'h7e, 8'h11, 8'h13});
  endproperty
  a_raw: assert property (p_raw)
    else $error("reserved byte sent unstuffed");
  property p_esc;
    tk && esc_ff |-> eff inside {8'h7e, 8'h7d, 8'h11, 8'h13};
  endproperty
  a_esc: assert property (p_esc)
    else $error("escape used on plain byte");
endmodule // sfc_link_chk

// >>> verif/sfc_serial_api_frame_codec_tb.sv
`timescale 1ns/100ps
module sfc_serial_api_frame_codec_tb;
  typedef struct {
    logic [1:0] m;
    int n;
    logic [31:0] d;
    logic [7:0] cs;
  } sfc_row_t;
  // ********************************
  // signals and instances
  // ********************************
  logic clk_sys = 0, sys_rst = 1, spi_b = 0, full_seen = 0, clk_en = 1;
  logic [1:0] mode = 0, mode_b = 1;
  logic [7:0] cmd_data = 0, tx_data = 0, rx_data, resp_data, rx_data_b;
  logic [7:0] lastb;
  logic cmd_valid = 0, cmd_last = 0, cmd_ready, tx_valid = 0, tx_last = 0;
  logic tx_ready, rx_valid, rx_first, rx_last, rx_ready = 1, rx_drop;
  logic resp_valid, resp_ready = 0, rx_valid_b, rx_drop_b;
  logic [9:0] eq_rx[$], e_rx;
  logic [7:0] eq_resp[$];
  int fail_count = 0, checks = 0, nrx = 0, ndrop = 0;
  sfc_row_t rows[6] = '{'{2'h1, 1, 32'h23, 8'hdc},
    '{2'h2, 2, 32'h1123, 8'hcb}, '{2'h2, 3, 32'h137d7e, 8'hf1},
    '{2'h2, 1, 32'hee, 8'h11}, '{2'h1, 1, 32'h7e, 8'h81},
    '{2'h0, 2, 32'h4241, 8'h00}};
  sfc_link_if link();
  sfc_link_if link_b();
  sfc_dev u_sfc_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .framing_mode_select(mode), .link_is_spi(1'b0), .link(link),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_last(rx_last), .rx_ready(rx_ready), .rx_drop(rx_drop),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready));
  sfc_host u_sfc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .framing_mode_select(mode), .link(link), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .resp_data(resp_data), .resp_valid(resp_valid),
    .resp_ready(resp_ready));
  sfc_dev u_sfc_dev_b (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en),
    .framing_mode_select(mode_b), .link_is_spi(spi_b), .link(link_b),
    .rx_data(rx_data_b), .rx_valid(rx_valid_b), .rx_first(),
    .rx_last(), .rx_ready(resp_ready), .rx_drop(rx_drop_b),
    .tx_data(8'h00), .tx_valid(1'b0), .tx_last(1'b0), .tx_ready());
  sfc_link_chk u_sfc_link_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .framing_mode_select(mode), .h2d_data(link.h2d_data),
    .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
    .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
    .d2h_ready(link.d2h_ready));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ********************************
  // tasks
  // ********************************
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic put(logic [1:0] m, logic [7:0] b, bit plain);
    if (m == 2'h2 && !plain && b inside {8'h7e, 8'h7d, 8'h11, 8'h13}) begin
      eq_resp.push_back(8'h7d);
      eq_resp.push_back(b ^ 8'h20);
    end else eq_resp.push_back(b);
  endtask
  task automatic send(bit w, int n, logic [127:0] d);
    for (int i = 0; i < n; i++) begin
      if (w) begin
        tx_valid <= 1;
        tx_data <= d[8*i+:8];
        tx_last <= i == n - 1;
      end else begin
        cmd_valid <= 1;
        cmd_data <= d[8*i+:8];
        cmd_last <= i == n - 1;
      end
      do @(posedge clk_sys); while ((w ? tx_ready : cmd_ready) !== 1'b1);
    end
    if (w) tx_valid <= 0;
    else cmd_valid <= 0;
    if (w) tx_data <= ~tx_data;
    else cmd_data <= ~cmd_data;
  endtask
  task automatic run(logic [1:0] m, int n, logic [127:0] d, logic [7:0] cs);
    int i;
    mode <= m;
    @(posedge clk_sys);
    if (m != 0) begin
      put(m, 8'h7e, 1);
      put(m, 8'h00, 0);
      put(m, n[7:0], 0);
    end
    for (i = 0; i < n; i++) begin
      put(m, d[8*i+:8], m == 0);
      eq_rx.push_back({i == 0, i == n - 1, d[8*i+:8]});
    end
    if (m != 0) put(m, cs, 0);
    fork
      send(0, n, d);
      send(1, n, d);
    join
    for (i = 0; i < 300 && eq_rx.size() + eq_resp.size() > 0; i++)
      @(posedge clk_sys);
    chk("drain", 16'(eq_rx.size() + eq_resp.size()), 0);
    $display("test done mode %0d len %0d", m, n);
  endtask
  task automatic raw(logic [1:0] m, bit s, logic [7:0] q[$], int er,
    int ed, logic [7:0] el);
    mode_b <= m;
    spi_b <= s;
    @(posedge clk_sys);
    nrx = 0;
    ndrop = 0;
    foreach (q[i]) begin
      link_b.h2d_valid <= 1;
      link_b.h2d_data <= q[i];
      do @(posedge clk_sys); while (link_b.h2d_ready !== 1'b1);
    end
    link_b.h2d_valid <= 0;
    link_b.h2d_data <= ~link_b.h2d_data;
    repeat (40) @(posedge clk_sys);
    chk("nrx", 16'(nrx), 16'(er));
    if (ed >= 0) chk("ndrop", 16'(ndrop), 16'(ed));
    if (er > 0) chk("lastb", lastb, el);
    $display("test done raw frame of %0d bytes", q.size());
  endtask
  // ********************************
  // monitors and stimulus
  // ********************************
  always @(posedge clk_sys) resp_ready <= !resp_ready;
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      e_rx = eq_rx.pop_front();
      if (mode == 0) chk("rx_data", rx_data, e_rx[7:0]);
      else chk("rx", {rx_first, rx_last, rx_data}, e_rx);
    end
    if (resp_valid === 1'b1 && resp_ready === 1'b1)
      chk("resp", resp_data, eq_resp.pop_front());
    if (rx_valid === 1'b1 && rx_ready === 1'b0) full_seen <= 1;
    if (rx_valid_b === 1'b1 && resp_ready === 1'b1) begin
      nrx++;
      lastb = rx_data_b;
    end
    if (rx_drop_b === 1'b1) ndrop++;
  end
  initial begin
    #750000;
    fail_count++;
    end_sim;
  end
  initial begin
    link_b.h2d_valid = 0;
    link_b.h2d_data = 0;
    link_b.d2h_ready = 1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    chk("rst", {link.d2h_valid, rx_valid, resp_valid, rx_drop}, 0);
    $display("test done reset");
    foreach (rows[i]) run(rows[i].m, rows[i].n, rows[i].d, rows[i].cs);
    rx_ready <= 0;
    fork
      run(1, 16, 128'h0f0e0d0c0b0a09080706050403020100, 8'h87);
      begin
        repeat (150) @(posedge clk_sys);
        chk("full", full_seen, 1);
        rx_ready <= 1;
      end
    join
    raw(1, 0, {8'h55, 8'haa, 8'h7e, 8'h00, 8'h01, 8'h23, 8'hdc}, 1, 0,
      8'h23);
    raw(1, 0, {8'h7e, 8'h00, 8'h01, 8'h23, 8'h00}, 0, 1, 0);
    raw(1, 0, {8'h7e, 8'h00, 8'h00, 8'hff}, 0, 1, 0);
    raw(2, 0, {8'h7e, 8'h00, 8'h02, 8'h23, 8'h7e, 8'h00, 8'h01, 8'h23,
      8'hdc}, 1, -1, 8'h23);
    raw(2, 1, {8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d, 8'h31, 8'hcb}, 0, 1,
      0);
    clk_en <= 0;
    raw(1, 0, {8'h7e, 8'h00, 8'h01, 8'h23, 8'hdc}, 0, 0, 0);
    clk_en <= 1;
    raw(2, 0, {8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d, 8'h31, 8'hcb}, 2, 0,
      8'h11);
    end_sim;
  end
endmodule // sfc_serial_api_frame_codec_tb
